// file: core/cocl_options.v
// option registers E5h and F0h of the converter and the logic they steer
// Contract
// - averaging codes 00/10/11 give 16/8/32 samples
// - averaging code 01 passes every sample straight
// - auto mask blocks set faults after answered alert
// - auto mask off: alert reasserts, host masks
// - range 11/10/01 forces half/quarter/eighth divider
// - range 00 follows loop scale for divider
// - bad strap holds loop master driver off unless allowed
// - bad strap flag cleared only by reset
// - drive-on-bad-strap bit acts at once
// - reset-on-shutdown restores target on shutdown events
// - strap disable restores target from nonvolatile store
// - low margin restore fff7h or fff1h
// - high margin restore 0009h or 000fh
// - unignored overvoltage fault latches low-side switch
// - select 0 holds until startup or clear while disabled
// - select 1 releases below 0.2 V feedback
// - misc word at F0h, storable
// - options word at E5h, storable
`include "cocl_map.vh"

module cocl_options #(
  parameter AW = 12
) (
  input  wire          clk,
  input  wire          rst,
  // command port from the PMBus engine
  input  wire [7:0]    cmd_code,
  input  wire          cmd_wr,
  input  wire [15:0]   cmd_wdata,
  input  wire          cmd_rd,
  output wire          cmd_hit,
  output reg  [15:0]   cmd_rdata_q,
  // nonvolatile store
  input  wire          store_all,
  input  wire          restore_all,
  input  wire [15:0]   nvm_opt_word,
  input  wire [15:0]   nvm_misc_word,
  input  wire [15:0]   nvm_target,
  output reg           nvm_store_q,
  output reg  [15:0]   nvm_opt_wdata_q,
  output reg  [15:0]   nvm_misc_wdata_q,
  // telemetry samples and readings
  input  wire          smp_vld,
  input  wire [1:0]    smp_ch,
  input  wire [AW-1:0] smp_data,
  output wire          reading_vld,
  output wire [1:0]    reading_ch,
  output wire [AW-1:0] reading_data,
  output wire          adc_enable,
  output wire          vout_only_mode,
  // output voltage divider
  input  wire [1:0]    vout_scale_loop,
  output reg  [1:0]    vout_div_sel_q,
  // alert
  input  wire [7:0]    fault_src,
  input  wire [7:0]    host_fault_mask,
  input  wire          ara_answered,
  input  wire          clear_faults,
  output wire          alert_assert,
  output reg  [7:0]    auto_mask_q,
  // strap and driver
  input  wire          strap_done,
  input  wire          boot_voltage_strap_ok,
  input  wire [15:0]   strap_target,
  input  wire          loop_master,
  input  wire          op_on_request,
  output reg           bad_strap_status_q,
  output wire          driver_enable,
  // output target
  input  wire          fault_shutdown,
  input  wire          fault_restart,
  input  wire          ctl_shutdown,
  input  wire          low_vin,
  output reg           target_load_q,
  output reg  [15:0]   target_default_q,
  // margin restore values
  output reg  [15:0]   margin_lo_default_q,
  output reg  [15:0]   margin_hi_default_q,
  // overvoltage and low-side switch
  input  wire          ov_fault,
  input  wire          ov_resp_ignore,
  input  wire          startup_begin,
  input  wire          state_disabled,
  input  wire          feedback_below_0p2_pin,
  output reg           lowside_on_q,
  // plain option bits toward the power stage
  output wire          neg_ilim_disable,
  output wire          reset_b_mode,
  output wire          data_limit_override,
  output wire [1:0]    hsoc_user_trim,
  output wire          avs_user_en,
  output wire          force_sync_out,
  output wire          force_sync_in,
  output wire          sync_fault_disable
);

  // divider chosen by the range field, or by the loop scale when it is 00
  function [1:0] div_pick;
    input [1:0] rng;
    input [1:0] scale;
    begin
      case (rng)
        `COCL_RNG_HALF:    div_pick = `COCL_DIV_HALF;
        `COCL_RNG_QUARTER: div_pick = `COCL_DIV_QUARTER;
        `COCL_RNG_EIGHTH:  div_pick = `COCL_DIV_EIGHTH;
        default:
        begin
          case (scale)
            `COCL_SCALE_HALF:    div_pick = `COCL_DIV_QUARTER;
            `COCL_SCALE_QUARTER: div_pick = `COCL_DIV_EIGHTH;
            default:             div_pick = `COCL_DIV_HALF;
          endcase
        end
      endcase
    end
  endfunction

  reg  [15:0] opt_q;
  reg  [15:0] misc_q;
  reg         fdbk_sync1_q;
  reg         fdbk_sync2_q;
  reg         strap_ok_q;
  reg         strap_seen_q;

  wire        hit_opt  = (cmd_code == `COCL_CMD_OPTIONS);
  wire        hit_misc = (cmd_code == `COCL_CMD_MISC);
  wire [1:0]  avg_sel  = {opt_q[`COCL_OPT_AVG_HI], opt_q[`COCL_OPT_AVG_LO]};
  wire [1:0]  rng_sel  = {opt_q[`COCL_OPT_RNG_HI], opt_q[`COCL_OPT_RNG_LO]};
  wire        auto_en  = opt_q[`COCL_OPT_AUTO_ARA];
  wire        drv_bad  = opt_q[`COCL_OPT_DRV_BAD];
  wire        tgt_rst  = opt_q[`COCL_OPT_TGT_RST];
  wire        strap_ds = opt_q[`COCL_OPT_STRAP_DIS];
  wire        ov_sel   = misc_q[`COCL_MISC_OV_SEL];
  wire        shutdown_evt;

  assign cmd_hit = hit_opt | hit_misc;

  // plain option bits
  assign neg_ilim_disable    = opt_q[`COCL_OPT_DIS_NEGI];
  assign reset_b_mode        = opt_q[`COCL_OPT_RESET_B];
  assign adc_enable          = opt_q[`COCL_OPT_ADC_EN];
  assign vout_only_mode      = opt_q[`COCL_OPT_VSM];
  assign data_limit_override = opt_q[`COCL_OPT_DLO];
  assign hsoc_user_trim      = {misc_q[`COCL_MISC_HSOC_HI], misc_q[`COCL_MISC_HSOC_LO]};
  assign avs_user_en         = misc_q[`COCL_MISC_AVS];
  assign force_sync_out      = misc_q[`COCL_MISC_SYNC_OUT];
  assign force_sync_in       = misc_q[`COCL_MISC_SYNC_IN];
  assign sync_fault_disable  = misc_q[`COCL_MISC_SYNC_DIS];

  // option registers: a write masks out reserved bits, a restore reloads
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opt_q  <= `COCL_OPT_RESET;
      misc_q <= `COCL_MISC_RESET;
    end
    else if (restore_all)
    begin
      opt_q  <= nvm_opt_word & `COCL_OPT_WMASK;
      misc_q <= nvm_misc_word & `COCL_MISC_WMASK;
    end
    else if (cmd_wr)
    begin
      if (hit_opt)
        opt_q <= cmd_wdata & `COCL_OPT_WMASK;
      if (hit_misc)
        misc_q <= cmd_wdata & `COCL_MISC_WMASK;
    end
  end

  // readback; an unmapped code reads as zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_rdata_q <= 16'h0000;
    else if (cmd_rd)
    begin
      if (hit_opt)
        cmd_rdata_q <= opt_q;
      else if (hit_misc)
        cmd_rdata_q <= misc_q;
      else
        cmd_rdata_q <= 16'h0000;
    end
  end

  // store-all snapshots both words for the nonvolatile writer
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nvm_store_q      <= 1'b0;
      nvm_opt_wdata_q  <= 16'h0000;
      nvm_misc_wdata_q <= 16'h0000;
    end
    else
    begin
      nvm_store_q <= store_all;
      if (store_all)
      begin
        nvm_opt_wdata_q  <= opt_q;
        nvm_misc_wdata_q <= misc_q;
      end
    end
  end

  // telemetry averaging; depth follows the field at once
  cocl_avg #(
    .W  (AW),
    .CH (3)
  ) u_avg (
    .clk       (clk),
    .rst       (rst),
    .avg_sel   (avg_sel),
    .smp_vld   (smp_vld & adc_enable),
    .smp_ch    (smp_ch),
    .smp_data  (smp_data),
    .rd_vld_q  (reading_vld),
    .rd_ch_q   (reading_ch),
    .rd_data_q (reading_data)
  );

  // measurement divider, registered to keep the analog select glitch free
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      vout_div_sel_q <= `COCL_DIV_HALF;
    else
      vout_div_sel_q <= div_pick(rng_sel, vout_scale_loop);
  end

  // auto mask: latched set faults win over a clear in the same cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      auto_mask_q <= 8'h00;
    else if (ara_answered & auto_en)
      auto_mask_q <= auto_mask_q | fault_src;
    else if (clear_faults)
      auto_mask_q <= 8'h00;
  end

  // with auto mask off, once a clear has emptied the auto mask, only the host mask holds a persistent fault back
  assign alert_assert = |(fault_src & ~auto_mask_q & ~host_fault_mask);

  // strap detection result, taken once after reset and held until the next reset
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_ok_q         <= 1'b0;
      strap_seen_q       <= 1'b0;
      bad_strap_status_q <= 1'b0;
    end
    else if (strap_done & ~strap_seen_q)
    begin
      strap_seen_q <= 1'b1;
      strap_ok_q   <= boot_voltage_strap_ok;
      // set once per reset by an invalid strap unless strap disable is set; only reset clears it
      bad_strap_status_q <= ~boot_voltage_strap_ok & ~strap_ds;
    end
  end

  // combinational so a change of the bit acts in the same cycle
  assign driver_enable = op_on_request &
                         (~loop_master | ~bad_strap_status_q | drv_bad);

  assign shutdown_evt = fault_shutdown | fault_restart | ctl_shutdown | low_vin;

  // default target: nonvolatile copy when strap disabled or strap not usable
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      target_default_q <= 16'h0000;
      target_load_q    <= 1'b0;
    end
    else
    begin
      if (strap_ds | ~strap_ok_q)
        target_default_q <= nvm_target;
      else
        target_default_q <= strap_target;
      target_load_q <= tgt_rst & shutdown_evt;
    end
  end

  // margin restore values track their select bits
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      margin_lo_default_q <= `COCL_MLO_DEF0;
      margin_hi_default_q <= `COCL_MHI_DEF0;
    end
    else
    begin
      margin_lo_default_q <= opt_q[`COCL_OPT_MLO_SEL] ? `COCL_MLO_DEF1 : `COCL_MLO_DEF0;
      margin_hi_default_q <= opt_q[`COCL_OPT_MHI_SEL] ? `COCL_MHI_DEF1 : `COCL_MHI_DEF0;
    end
  end

  // the comparator output is asynchronous to clk
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fdbk_sync1_q <= 1'b0;
      fdbk_sync2_q <= 1'b0;
    end
    else
    begin
      fdbk_sync1_q <= feedback_below_0p2_pin;
      fdbk_sync2_q <= fdbk_sync1_q;
    end
  end

  // low-side latch: a new fault wins over any release in the same cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      lowside_on_q <= 1'b0;
    else if (ov_fault & ~ov_resp_ignore)
      lowside_on_q <= 1'b1;
    else if (~ov_sel & (startup_begin | (clear_faults & state_disabled)))
      lowside_on_q <= 1'b0;
    else if (ov_sel & fdbk_sync2_q)
      lowside_on_q <= 1'b0;
  end

endmodule // cocl_options

// file: core/cocl_map.vh
// command codes, field positions, reset values and constants of the option logic
`ifndef COCL_MAP_VH
`define COCL_MAP_VH

// command codes
`define COCL_CMD_OPTIONS   8'he5
`define COCL_CMD_MISC      8'hf0

// options word fields
`define COCL_OPT_DIS_NEGI  0
`define COCL_OPT_RESET_B   1
`define COCL_OPT_ADC_EN    2
`define COCL_OPT_VSM       3
`define COCL_OPT_DLO       4
`define COCL_OPT_AVG_LO    5
`define COCL_OPT_AVG_HI    6
`define COCL_OPT_AUTO_ARA  7
`define COCL_OPT_RNG_LO    8
`define COCL_OPT_RNG_HI    9
`define COCL_OPT_DRV_BAD   10
`define COCL_OPT_TGT_RST   11
`define COCL_OPT_STRAP_DIS 12
`define COCL_OPT_MLO_SEL   13
`define COCL_OPT_MHI_SEL   14
`define COCL_OPT_RESET     16'h0084
`define COCL_OPT_WMASK     16'h7fff

// misc word fields
`define COCL_MISC_OV_SEL   0
`define COCL_MISC_HSOC_LO  1
`define COCL_MISC_HSOC_HI  2
`define COCL_MISC_AVS      4
`define COCL_MISC_SYNC_OUT 6
`define COCL_MISC_SYNC_IN  7
`define COCL_MISC_SYNC_DIS 8
`define COCL_MISC_RESET    16'h0013
`define COCL_MISC_WMASK    16'h01d7

// averaging codes
`define COCL_AVG_16        2'h0
`define COCL_AVG_BYPASS    2'h1
`define COCL_AVG_8         2'h2
`define COCL_AVG_32        2'h3

// loop scale codes and divider selections
`define COCL_SCALE_1       2'h0
`define COCL_SCALE_HALF    2'h1
`define COCL_SCALE_QUARTER 2'h2
`define COCL_RNG_FOLLOW    2'h0
`define COCL_RNG_EIGHTH    2'h1
`define COCL_RNG_QUARTER   2'h2
`define COCL_RNG_HALF      2'h3
`define COCL_DIV_HALF      2'h0
`define COCL_DIV_QUARTER   2'h1
`define COCL_DIV_EIGHTH    2'h2

// step margin restore values
`define COCL_MLO_DEF0      16'hfff7
`define COCL_MLO_DEF1      16'hfff1
`define COCL_MHI_DEF0      16'h0009
`define COCL_MHI_DEF1      16'h000f

`endif

// file: core/cocl_avg.v
// accumulating averager shared by the current, temperature and output voltage channels
`include "cocl_map.vh"

module cocl_avg #(
  parameter W  = 12,
  parameter CH = 3
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [1:0]   avg_sel,
  input  wire         smp_vld,
  input  wire [1:0]   smp_ch,
  input  wire [W-1:0] smp_data,
  output reg          rd_vld_q,
  output reg  [1:0]   rd_ch_q,
  output reg  [W-1:0] rd_data_q
);

  // log2 of the sample count for each averaging code
  function [2:0] avg_shift;
    input [1:0] sel;
    begin
      case (sel)
        `COCL_AVG_16:     avg_shift = 3'h4;
        `COCL_AVG_8:      avg_shift = 3'h3;
        `COCL_AVG_32:     avg_shift = 3'h5;
        default:          avg_shift = 3'h0;
      endcase
    end
  endfunction

  reg  [W+4:0] acc_q [0:CH-1];
  reg  [4:0]   cnt_q [0:CH-1];
  reg  [1:0]   sel_q;
  wire [2:0]   shift = avg_shift(avg_sel);
  wire [4:0]   last  = (5'h1 << shift) - 5'h1;
  wire [W+4:0] sum   = acc_q[smp_ch] + {5'h0, smp_data};
  wire [W+4:0] avg   = sum >> shift;
  integer i;

  // a change of depth restarts every channel so no mixed-depth result leaks out
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_q     <= `COCL_AVG_16;
      rd_vld_q  <= 1'b0;
      rd_ch_q   <= 2'h0;
      rd_data_q <= {W{1'b0}};
      for (i = 0; i < CH; i = i + 1)
      begin
        acc_q[i] <= {(W+5){1'b0}};
        cnt_q[i] <= 5'h0;
      end
    end
    else
    begin
      sel_q    <= avg_sel;
      rd_vld_q <= 1'b0;
      if (sel_q != avg_sel)
      begin
        for (i = 0; i < CH; i = i + 1)
        begin
          acc_q[i] <= {(W+5){1'b0}};
          cnt_q[i] <= 5'h0;
        end
      end
      else if (smp_vld)
      begin
        if (cnt_q[smp_ch] == last) // bypass has last = 0: every sample reports
        begin
          rd_vld_q       <= 1'b1;
          rd_ch_q        <= smp_ch;
          rd_data_q      <= avg[W-1:0];
          acc_q[smp_ch]  <= {(W+5){1'b0}};
          cnt_q[smp_ch]  <= 5'h0;
        end
        else
        begin
          acc_q[smp_ch] <= sum;
          cnt_q[smp_ch] <= cnt_q[smp_ch] + 5'h1;
        end
      end
    end
  end

endmodule // cocl_avg

// file: testbench/cocl_options_monitor.sv
// assertion checker for the converter option registers
module cocl_options_monitor (
  input wire        clk,
  input wire        rst,
  input wire [7:0]  cmd_code,
  input wire        cmd_rd,
  input wire        cmd_hit,
  input wire [15:0] cmd_rdata_q,
  input wire        store_all,
  input wire        nvm_store_q,
  input wire        ara_answered,
  input wire        clear_faults,
  input wire [7:0]  auto_mask_q,
  input wire        op_on_request,
  input wire        driver_enable,
  input wire        bad_strap_status_q,
  input wire        fault_shutdown,
  input wire        fault_restart,
  input wire        ctl_shutdown,
  input wire        low_vin,
  input wire        target_load_q,
  input wire        ov_fault,
  input wire        ov_resp_ignore,
  input wire        startup_begin,
  input wire        feedback_below_0p2_pin,
  input wire        lowside_on_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // shutdown causes folded so the past value is one signal
  wire evt_any = fault_shutdown | fault_restart | ctl_shutdown | low_vin;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_cmd_decode: assert property (
    cmd_hit == (cmd_code == 8'he5 || cmd_code == 8'hf0)) else $error("bad decode");
  chk_rd_unmapped: assert property (
    cmd_rd && !cmd_hit |=> cmd_rdata_q == 16'h0000) else $error("unmapped not zero");
  chk_store_pulse: assert property (
    store_all |=> nvm_store_q) else $error("no store pulse");
  chk_ov_latch: assert property (
    ov_fault && !ov_resp_ignore |=> lowside_on_q) else $error("switch not latched");
  // three quiet feedback samples rule out the sensed release path
  chk_lowside_hold: assert property (
    !feedback_below_0p2_pin [*3] ##0 (lowside_on_q && !startup_begin && !clear_faults)
    |=> lowside_on_q) else $error("switch dropped");
  chk_bad_sticky: assert property (
    bad_strap_status_q |=> bad_strap_status_q) else $error("strap flag cleared");
  chk_drive_needs_on: assert property (
    driver_enable |-> op_on_request) else $error("driver without request");
  chk_mask_steady: assert property (
    !ara_answered && !clear_faults |=> $stable(auto_mask_q)) else $error("mask moved");
  chk_target_cause: assert property (
    $rose(target_load_q) |-> $past(evt_any)) else $error("load without cause");
  cov_ara: cover property (ara_answered ##1 auto_mask_q != 8'h00);
  cov_ov: cover property (ov_fault ##1 lowside_on_q);
  cov_tgt: cover property (target_load_q);
endmodule // cocl_options_monitor

bind cocl_options cocl_options_monitor u_mon (.*);

// file: testbench/cocl_host_model.sv
// host-side command master for the option registers
module cocl_host_model (
  input  wire        clk,
  input  wire [15:0] cmd_rdata_q,
  output reg  [7:0]  cmd_code,
  output reg         cmd_wr,
  output reg  [15:0] cmd_wdata,
  output reg         cmd_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle command port
  initial
  begin
    {cmd_code, cmd_wr, cmd_wdata, cmd_rd} = 26'h0;
  end
  // one taking edge; data scrambled once released so stale words never pass
  task wr(input [7:0] c, input [15:0] d);
  begin
    @(posedge clk);
    #1 cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(posedge clk);
    #1 cmd_wr = 1'b0;
    cmd_wdata = ~d;
  end
  endtask
  // word is registered by the edge that takes the strobe
  task rd(input [7:0] c, output [15:0] q);
  begin
    @(posedge clk);
    #1 cmd_code = c;
    cmd_rd = 1'b1;
    @(posedge clk);
    #1 cmd_rd = 1'b0;
    q = cmd_rdata_q;
  end
  endtask
endmodule // cocl_host_model

// file: testbench/converter_option_config_logic_tb_top.sv
// self-checking bench for the converter option registers
module converter_option_config_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk, rst, smp_vld, boot_voltage_strap_ok, loop_master, op_on_request;
  reg ov_resp_ignore, state_disabled, feedback_below_0p2_pin, restore_all;
  reg [9:0] pls;
  reg [1:0] smp_ch, vout_scale_loop;
  reg [11:0] smp_data;
  reg [7:0] fault_src, host_fault_mask;
  reg [15:0] nvm_opt_word, nvm_misc_word, nvm_target, strap_target, q;
  wire [7:0] cmd_code, auto_mask_q;
  wire [15:0] cmd_wdata, cmd_rdata_q, nvm_opt_wdata_q, nvm_misc_wdata_q, target_default_q;
  wire [15:0] margin_lo_default_q, margin_hi_default_q;
  wire [11:0] reading_data;
  wire [1:0] vout_div_sel_q, reading_ch, hsoc_user_trim;
  wire adc_enable, vout_only_mode, neg_ilim_disable, reset_b_mode, data_limit_override;
  wire avs_user_en, force_sync_out, force_sync_in, sync_fault_disable;
  wire cmd_wr, cmd_rd, cmd_hit, nvm_store_q, reading_vld, alert_assert;
  wire bad_strap_status_q, driver_enable, target_load_q, lowside_on_q;
  integer err_total, checked, seed, i, j, n, s;
  integer sq[$];
  // event strobes share one vector so a single task pulses any of them
  wire store_all = pls[0];
  wire ara_answered = pls[1];
  wire clear_faults = pls[2];
  wire ov_fault = pls[3];
  wire startup_begin = pls[4];
  wire strap_done = pls[5];
  wire fault_shutdown = pls[6];
  wire fault_restart = pls[7];
  wire ctl_shutdown = pls[8];
  wire low_vin = pls[9];
  // plain option outputs gathered for one comparison
  wire [15:0] opt_bits = {5'h00, neg_ilim_disable, reset_b_mode, adc_enable, vout_only_mode,
    data_limit_override, hsoc_user_trim, avs_user_en, force_sync_out, force_sync_in,
    sync_fault_disable};

  cocl_options DUT (.*);
  cocl_host_model h (.*);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task tk(input integer k);
  begin
    repeat (k) @(posedge clk);
    #1;
  end
  endtask
  // leading edge keeps a strobe from being lowered and raised in one step
  task pl(input [9:0] m);
  begin
    tk(1);
    pls = m;
    tk(1);
    pls = 10'h000;
  end
  endtask
  task chk(input [15:0] e, input [15:0] v, input [63:0] nm);
  begin
    checked = checked + 1;
    if (v !== e)
    begin
      err_total = err_total + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, v);
    end
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // the sequence needs under two thousand cycles
  initial
  begin
    #100000;
    err_total = err_total + 1;
    conclude;
  end

  initial
  begin
    seed = 32'hed5f;
    err_total = 0;
    checked = 0;
    {rst, smp_vld, boot_voltage_strap_ok, loop_master, op_on_request} = 5'h10;
    {ov_resp_ignore, state_disabled, feedback_below_0p2_pin, restore_all, pls} = 14'h0000;
    {smp_ch, vout_scale_loop, smp_data, fault_src, host_fault_mask} = 32'h0;
    {nvm_opt_word, nvm_misc_word, nvm_target, strap_target} = 64'h9234_ffff_0a5c_0c3a;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    // reset words, reserved bits, unmapped place, margin values, snapshot
    h.rd(8'he5, q);
    chk(16'h0084, q, "opt");
    h.rd(8'hf0, q);
    chk(16'h0013, q, "misc");
    chk(16'hfff7, margin_lo_default_q, "mlo");
    chk(16'h0009, margin_hi_default_q, "mhi");
    h.wr(8'hf0, 16'hffff);
    h.rd(8'hf0, q);
    chk(16'h01d7, q, "misc");
    h.wr(8'h5a, 16'hffff);
    h.rd(8'h5a, q);
    chk(16'h0000, q, "unmap");
    h.wr(8'he5, 16'hffff);
    h.rd(8'he5, q);
    chk(16'h7fff, q, "opt");
    chk(16'hfff1, margin_lo_default_q, "mlo");
    chk(16'h000f, margin_hi_default_q, "mhi");
    pl(10'h001);
    chk(16'h0001, nvm_store_q, "store");
    chk(16'h7fff, nvm_opt_wdata_q, "snap");
    chk(16'h01d7, nvm_misc_wdata_q, "snapm");
    $display("register test done");
    // every divider selection against every loop scale
    for (i = 0; i < 4; i = i + 1)
      for (j = 0; j < 3; j = j + 1)
      begin
        vout_scale_loop = j[1:0];
        h.wr(8'he5, {6'h00, i[1:0], 8'h84});
        tk(1);
        chk(16'((i == 0) ? j : 3 - i), vout_div_sel_q, "div");
      end
    $display("divider test done");
    // every averaging depth with random samples; depth change needs a settle gap
    for (i = 0; i < 4; i = i + 1)
    begin
      n = (i == 0) ? 16 : (i == 1) ? 1 : (i == 2) ? 8 : 32;
      h.wr(8'he5, {8'h00, 1'b1, i[1:0], 5'h04});
      tk(2);
      s = 0;
      smp_ch = 2'h1;
      smp_vld = 1'b1;
      for (j = 0; j < n; j = j + 1)
      begin
        smp_data = 12'($random(seed));
        sq.push_back(smp_data);
        tk(1);
      end
      smp_vld = 1'b0;
      // reference model: plain mean of the queued samples
      while (sq.size() > 0)
        s = s + sq.pop_front();
      for (j = 0; j < 3 && reading_vld !== 1'b1; j = j + 1)
        tk(1);
      chk(16'h0001, reading_vld, "rvld");
      chk(16'(s / n), reading_data, "read");
      chk(16'h0001, reading_ch, "rch");
    end
    $display("averaging test done");
    // auto masking after an answered alert, then host masking with it off
    fault_src = 8'($random(seed)) | 8'h01;
    pl(10'h002);
    chk({8'h00, fault_src}, auto_mask_q, "mask");
    chk(16'h0000, alert_assert, "alert");
    h.wr(8'he5, 16'h0004);
    pl(10'h004);
    pl(10'h002);
    chk(16'h0000, auto_mask_q, "mask");
    chk(16'h0001, alert_assert, "alert");
    host_fault_mask = fault_src;
    #1 chk(16'h0000, alert_assert, "alert");
    $display("alert test done");
    // low-side latch under both release modes
    ov_resp_ignore = 1'b1;
    pl(10'h008);
    chk(16'h0000, lowside_on_q, "ls");
    ov_resp_ignore = 1'b0;
    pl(10'h008);
    chk(16'h0001, lowside_on_q, "ls");
    feedback_below_0p2_pin = 1'b1;
    tk(2);
    chk(16'h0001, lowside_on_q, "ls");
    tk(1);
    chk(16'h0000, lowside_on_q, "ls");
    feedback_below_0p2_pin = 1'b0;
    h.wr(8'hf0, 16'h0012);
    pl(10'h008);
    feedback_below_0p2_pin = 1'b1;
    pl(10'h004);
    chk(16'h0001, lowside_on_q, "ls");
    state_disabled = 1'b1;
    pl(10'h004);
    chk(16'h0000, lowside_on_q, "ls");
    state_disabled = 1'b0;
    pl(10'h008);
    pl(10'h010);
    chk(16'h0000, lowside_on_q, "ls");
    feedback_below_0p2_pin = 1'b0;
    $display("overvoltage test done");
    // each shutdown cause reloads the target while the bit is set; fault shutdown alone is tried with it clear
    pl(10'h040);
    chk(16'h0000, target_load_q, "load");
    h.wr(8'he5, 16'h0884);
    for (i = 0; i < 4; i = i + 1)
    begin
      pl(10'h040 << i);
      chk(16'h0001, target_load_q, "load");
    end
    $display("target test done");
    // bad strap keeps the master driver off until the bit allows it
    {loop_master, op_on_request} = 2'h3;
    pl(10'h020);
    chk(16'h0001, bad_strap_status_q, "bad");
    chk(16'h0000, driver_enable, "drv");
    h.wr(8'he5, 16'h0484);
    chk(16'h0001, driver_enable, "drv");
    boot_voltage_strap_ok = 1'b1;
    pl(10'h020);
    chk(16'h0001, bad_strap_status_q, "bad");
    // second reset: strap disable takes the stored target over a good strap
    rst = 1'b1;
    tk(2);
    rst = 1'b0;
    h.wr(8'he5, 16'h1084);
    pl(10'h020);
    tk(1);
    chk(16'h0000, bad_strap_status_q, "bad");
    chk(nvm_target, target_default_q, "tgt");
    $display("strap test done");
    // restore reloads both words with reserved bits dropped
    restore_all = 1'b1;
    tk(1);
    restore_all = 1'b0;
    h.rd(8'hf0, q);
    chk(16'h01d7, q, "rmisc");
    h.rd(8'he5, q);
    chk(16'h1234, q, "ropt");
    chk(16'h017f, opt_bits, "bits");
    $display("restore test done");
    conclude;
  end
endmodule // converter_option_config_logic_tb_top
